// >>> rtl/acrb_map.svh
// Purpose: address map, field positions and reset values of the adc configuration bank
// Assumes: 8-bit addresses and 8-bit data words
// Notes: shadowed registers only reach the converter through a commit
//
// Overview of operation
// - reset loads every configuration register with its listed default
// - function registers 0x08, 0x09, 0x0D and 0x0E take host writes into a holding copy
// - held values act only after the host writes 0x01 to address 0xFF
// - commit copies every holding copy into the working copy together
// - commit bit clears itself once the update has been done
// - port config mirrors bit order at 6/1, soft reset at 5/2, reads 0x18
// - speed grade code read-only in bits 5:4, other bits zero
// - power field selects normal, power-down or standby; bit 5 steers the pin
// - 3-bit pattern field replaces output data with the chosen test pattern
`ifndef ACRB_MAP_SVH
`define ACRB_MAP_SVH

`define ACRB_ADDR_PORT_CFG   8'h00
`define ACRB_ADDR_PART_ID    8'h01
`define ACRB_ADDR_GRADE      8'h02
`define ACRB_ADDR_POWER      8'h08
`define ACRB_ADDR_CLOCK      8'h09
`define ACRB_ADDR_PATTERN    8'h0D
`define ACRB_ADDR_SELF_TEST  8'h0E
`define ACRB_ADDR_COMMIT     8'hFF

`define ACRB_RST_PORT_CFG    8'h18
`define ACRB_RST_POWER       8'h80
`define ACRB_RST_CLOCK       8'h01
`define ACRB_RST_PATTERN     8'h00
`define ACRB_RST_SELF_TEST   8'h04
`define ACRB_RST_COMMIT      8'h00

// writable bits of each shadowed register
`define ACRB_MASK_POWER      8'h23
`define ACRB_MASK_CLOCK      8'h01
`define ACRB_MASK_PATTERN    8'h37
`define ACRB_MASK_SELF_TEST  8'h05

`define ACRB_PORT_LSB_HI     6
`define ACRB_PORT_LSB_LO     1
`define ACRB_PORT_SRST_HI    5
`define ACRB_PORT_SRST_LO    2
`define ACRB_PWR_PIN_SEL     5
`define ACRB_CLK_DCS         0
`define ACRB_PAT_PN_LONG_RST 5
`define ACRB_PAT_PN_SHORT_RST 4
`define ACRB_BIST_SEQ_RST    2
`define ACRB_BIST_EN         0
`define ACRB_COMMIT_BIT      0
`define ACRB_GRADE_LSB       4

`endif

// >>> rtl/acrb_pkg.sv
// Purpose: types shared by the adc configuration bank
// Assumes: nothing beyond the map header
// Notes: encodings follow the register fields bit for bit
package acrb_pkg;

  typedef enum logic [1:0] {
    ACRB_PWR_NORMAL = 2'h0,
    ACRB_PWR_DOWN = 2'h1,
    ACRB_PWR_STANDBY = 2'h2,
    ACRB_PWR_NORMAL_ALT = 2'h3
  } acrb_power_e;

  typedef enum logic [2:0] {
    ACRB_PAT_OFF = 3'h0,
    ACRB_PAT_MIDSCALE = 3'h1,
    ACRB_PAT_POS_FULL = 3'h2,
    ACRB_PAT_NEG_FULL = 3'h3,
    ACRB_PAT_CHECKER = 3'h4,
    ACRB_PAT_LONG_PSEUDORANDOM = 3'h5,
    ACRB_PAT_SHORT_PSEUDORANDOM = 3'h6,
    ACRB_PAT_WORD_TOGGLE = 3'h7
  } acrb_pattern_e;

  typedef logic [7:0] acrb_byte_t;

endpackage

// >>> rtl/acrb_sh_if.sv
// Purpose: carrier between the bank controller and one shadowed register
// Assumes: single clock domain
// Notes: ctrl side drives strobes, store side returns both copies
`timescale 1ns/1ps
`default_nettype none
interface acrb_sh_if;
  logic we;
  logic [7:0] wdata;
  logic commit;
  logic soft_rst;
  logic [7:0] hold_q;
  logic [7:0] work_q;
  modport ctrl (output we, output wdata, output commit, output soft_rst,
                input hold_q, input work_q);
  modport store (input we, input wdata, input commit, input soft_rst,
                 output hold_q, output work_q);
endinterface
`default_nettype wire

// >>> rtl/acrb_shadow.sv
// Purpose: one double-buffered configuration register
// Assumes: strobes are one-cycle pulses from the bank controller
// Notes: open bits hold their reset value whatever the host writes
`timescale 1ns/1ps
`default_nettype none
module acrb_shadow
  import acrb_pkg::*;
#(
  parameter logic [7:0] RESET_VAL = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // controller side
  acrb_sh_if.store sh
);

  acrb_byte_t hold_reg;
  acrb_byte_t hold_next;
  acrb_byte_t work_reg;
  acrb_byte_t work_next;

  always_comb begin
    hold_next = hold_reg;
    work_next = work_reg;
    if (sh.soft_rst) begin
      hold_next = RESET_VAL;
      work_next = RESET_VAL;
    end else begin
      // host data only ever lands in the holding copy
      if (sh.we) begin
        hold_next = (sh.wdata & WMASK) | (RESET_VAL & ~WMASK);
      end
      if (sh.commit) begin
        work_next = hold_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_reg <= RESET_VAL;
      work_reg <= RESET_VAL;
    end else begin
      hold_reg <= hold_next;
      work_reg <= work_next;
    end
  end

  assign sh.hold_q = hold_reg;
  assign sh.work_q = work_reg;

endmodule // acrb_shadow
`default_nettype wire

// >>> rtl/acrb_bank.sv
// Purpose: configuration register bank of a high-speed converter
// Assumes: register strobes come from a serial frame decoder on the same clock
// Notes: reads return the holding copy; the working copy drives the converter
`timescale 1ns/1ps
`default_nettype none
`include "acrb_map.svh"
module acrb_bank
  import acrb_pkg::*;
#(
  parameter logic [7:0] PART_ID = 8'hA5, // arbitrary value
  parameter logic [1:0] SPEED_GRADE = 2'h1,
  parameter int NUM_SHADOW = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register access
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // pins
  input wire logic pdwn_pin,
  // converter controls
  output logic lsb_first,
  output logic power_down,
  output logic standby,
  output logic dcs_enable,
  output logic [2:0] test_pattern,
  output logic pn_long_reset,
  output logic pn_short_reset,
  output logic self_test_control,
  output logic bist_seq_reset
);

  localparam logic [7:0] SH_ADDR [NUM_SHADOW] = '{`ACRB_ADDR_POWER, `ACRB_ADDR_CLOCK,
    `ACRB_ADDR_PATTERN, `ACRB_ADDR_SELF_TEST};
  localparam logic [7:0] SH_RST [NUM_SHADOW] = '{`ACRB_RST_POWER, `ACRB_RST_CLOCK,
    `ACRB_RST_PATTERN, `ACRB_RST_SELF_TEST};
  localparam logic [7:0] SH_MASK [NUM_SHADOW] = '{`ACRB_MASK_POWER, `ACRB_MASK_CLOCK,
    `ACRB_MASK_PATTERN, `ACRB_MASK_SELF_TEST};
  localparam logic [7:0] PORT_RST = `ACRB_RST_PORT_CFG;
  localparam logic [7:0] COMMIT_RST = `ACRB_RST_COMMIT;

  ////////////////////////////////////////////////////////////////////////////
  // control state

  logic lsb_reg;
  logic lsb_next;
  logic soft_reg;
  logic soft_next;
  logic commit_reg;
  logic commit_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic wr_port;
  logic wr_commit;
  logic [7:0] hold_q [NUM_SHADOW];
  logic [7:0] work_q [NUM_SHADOW];

  assign wr_port = reg_wr && (reg_addr == `ACRB_ADDR_PORT_CFG);
  assign wr_commit = reg_wr && (reg_addr == `ACRB_ADDR_COMMIT);

  always_comb begin
    lsb_next = lsb_reg;
    soft_next = 1'b0;
    commit_next = commit_reg;
    if (soft_reg) begin
      lsb_next = PORT_RST[`ACRB_PORT_LSB_HI];
      commit_next = COMMIT_RST[`ACRB_COMMIT_BIT];
    end else begin
      if (wr_port) begin
        // either mirror copy counts, so the shift order never matters
        lsb_next = reg_wdata[`ACRB_PORT_LSB_HI] | reg_wdata[`ACRB_PORT_LSB_LO];
        soft_next = reg_wdata[`ACRB_PORT_SRST_HI] | reg_wdata[`ACRB_PORT_SRST_LO];
      end
      if (commit_reg) begin
        commit_next = 1'b0;
      end
      // a fresh commit write in the clearing cycle wins over the clear
      if (wr_commit) begin
        commit_next = reg_wdata[`ACRB_COMMIT_BIT];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lsb_reg <= 1'b0;
      soft_reg <= 1'b0;
      commit_reg <= 1'b0;
    end else begin
      lsb_reg <= lsb_next;
      soft_reg <= soft_next;
      commit_reg <= commit_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shadowed function registers

  for (genvar i = 0; i < NUM_SHADOW; i++) begin : g_sh
    acrb_sh_if sh_if ();
    assign sh_if.we = reg_wr && (reg_addr == SH_ADDR[i]);
    assign sh_if.wdata = reg_wdata;
    assign sh_if.commit = commit_reg;
    assign sh_if.soft_rst = soft_reg;
    assign hold_q[i] = sh_if.hold_q;
    assign work_q[i] = sh_if.work_q;
    acrb_shadow #(
      .RESET_VAL(SH_RST[i]),
      .WMASK(SH_MASK[i])
    ) u_sh (
      .clk(clk),
      .rst_n(rst_n),
      .sh(sh_if.store)
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // readback

  always_comb begin
    rdata_next = rdata_reg;
    rvalid_next = reg_rd;
    if (reg_rd) begin
      rdata_next = 8'h00; // unsupported locations read as zero
      case (reg_addr)
        `ACRB_ADDR_PORT_CFG: begin
          rdata_next = {1'b0, lsb_reg, soft_reg, 2'h3, soft_reg, lsb_reg, 1'b0};
        end
        `ACRB_ADDR_PART_ID: begin
          rdata_next = PART_ID;
        end
        `ACRB_ADDR_GRADE: begin
          rdata_next = {2'h0, SPEED_GRADE, 4'h0};
        end
        `ACRB_ADDR_COMMIT: begin
          rdata_next = {7'h00, commit_reg};
        end
        default: begin
          for (int k = 0; k < NUM_SHADOW; k++) begin
            if (reg_addr == SH_ADDR[k]) begin
              rdata_next = hold_q[k];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;

  ////////////////////////////////////////////////////////////////////////////
  // converter controls from the working copies and the bit-order flag, all registered except the sequence reset

  acrb_power_e pwr_mode;
  logic pin_to_standby;
  logic [9:0] ctl_reg;
  logic [9:0] ctl_next;

  assign pwr_mode = acrb_power_e'(work_q[0][1:0]);
  assign pin_to_standby = work_q[0][`ACRB_PWR_PIN_SEL];

  always_comb begin
    ctl_next = '0;
    ctl_next[0] = lsb_reg;
    // the pin acts on top of the register field
    ctl_next[1] = (pwr_mode == ACRB_PWR_DOWN) || (pdwn_pin && !pin_to_standby);
    ctl_next[2] = (pwr_mode == ACRB_PWR_STANDBY) || (pdwn_pin && pin_to_standby);
    ctl_next[3] = work_q[1][`ACRB_CLK_DCS];
    ctl_next[6:4] = work_q[2][2:0];
    ctl_next[7] = work_q[2][`ACRB_PAT_PN_LONG_RST];
    ctl_next[8] = work_q[2][`ACRB_PAT_PN_SHORT_RST];
    ctl_next[9] = work_q[3][`ACRB_BIST_EN];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_reg <= 10'h008; // dcs on, all else off
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign lsb_first = ctl_reg[0];
  assign power_down = ctl_reg[1];
  assign standby = ctl_reg[2];
  assign dcs_enable = ctl_reg[3];
  assign test_pattern = ctl_reg[6:4];
  assign pn_long_reset = ctl_reg[7];
  assign pn_short_reset = ctl_reg[8];
  assign self_test_control = ctl_reg[9];
  // sequence reset follows the working copy directly; it is a level, not data
  assign bist_seq_reset = work_q[3][`ACRB_BIST_SEQ_RST];

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_commit_clears: assert property (
    (commit_reg && !soft_reg && !wr_commit) |=> !commit_reg)
    else $error("commit bit did not clear itself");

  a_commit_copies: assert property (
    (commit_reg && !soft_reg) |=> (work_q[0] == $past(hold_q[0]))
      && (work_q[2] == $past(hold_q[2])))
    else $error("commit did not copy the holding values");

  a_hold_isolates: assert property (
    (!commit_reg && !soft_reg) |=> $stable(work_q[2]) && $stable(work_q[0]))
    else $error("working copy changed without a commit");

  a_write_to_hold: assert property (
    (reg_wr && reg_addr == `ACRB_ADDR_PATTERN && !soft_reg)
      |=> hold_q[2] == ($past(reg_wdata) & `ACRB_MASK_PATTERN))
    else $error("pattern write did not reach the holding copy");

  a_soft_defaults: assert property (
    soft_reg |=> (hold_q[0] == `ACRB_RST_POWER) && (work_q[3] == `ACRB_RST_SELF_TEST)
      && !lsb_reg && !commit_reg)
    else $error("soft reset did not restore defaults");

  a_soft_selfclear: assert property (
    soft_reg |=> !soft_reg)
    else $error("soft reset bit stuck");

  a_port_mirror: assert property (
    (reg_rd && reg_addr == `ACRB_ADDR_PORT_CFG) |=> reg_rvalid
      && (reg_rdata[6] == reg_rdata[1]) && (reg_rdata[5] == reg_rdata[2])
      && (reg_rdata[4:3] == 2'h3) && (reg_rdata[6] == $past(lsb_reg)))
    else $error("port configuration readback not mirrored");

  a_part_id: assert property (
    (reg_rd && reg_addr == `ACRB_ADDR_PART_ID) |=> reg_rdata == PART_ID)
    else $error("part identifier readback wrong");

  a_grade_read: assert property (
    (reg_rd && reg_addr == `ACRB_ADDR_GRADE) |=> reg_rdata == {2'h0, SPEED_GRADE, 4'h0})
    else $error("speed grade readback wrong");

  a_power_select: assert property (
    (pwr_mode == ACRB_PWR_DOWN) |=> power_down && ((pwr_mode == ACRB_PWR_STANDBY) || !standby
      || (pdwn_pin || $past(pdwn_pin))))
    else $error("power-down field not obeyed");

  a_pattern_out: assert property (
    ##1 test_pattern == $past(work_q[2][2:0]))
    else $error("test pattern output lags its field");

  c_commit: cover property (wr_commit && reg_wdata[0] ##1 commit_reg ##1 !commit_reg);
  c_soft_reset: cover property (wr_port && reg_wdata[`ACRB_PORT_SRST_LO] ##1 soft_reg);
  c_long_prbs: cover property (test_pattern == ACRB_PAT_LONG_PSEUDORANDOM);
  c_standby_pin: cover property (pdwn_pin && pin_to_standby ##1 standby);

endmodule // acrb_bank
`default_nettype wire

// >>> test/acrb_host_model.sv
// Purpose: serial-port master stand-in issuing register strobes to the bank
// Assumes: strobes launched by non-blocking assignment just after a rising edge
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module acrb_host_model (
  // clock
  input wire logic clk,
  // strobes to the bank
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  // read answer
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////////
  // callers pass zero in open bits, except for the writes aimed at the fully open read-only 0x01 and 0x02
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // held values only go live through 0x01 written to 0xFF
  task automatic commit();
    wr(8'hFF, 8'h01);
  endtask
  // answer is fixed at one cycle after the taken edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clk);
    d = reg_rdata;
    v = reg_rvalid;
  endtask
endmodule // acrb_host_model
`default_nettype wire

// >>> test/testbench.sv
// Purpose: self-checking bench of the adc configuration bank
// Assumes: host model owns the register strobes, bench owns clock, reset and pin
// Notes: default read-back is a table walked again after soft reset
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import acrb_pkg::*;
  localparam logic [7:0] PART_CODE = 8'h3C; // arbitrary value
  localparam logic [1:0] GRADE = 2'h2;
  typedef struct {logic [7:0] addr; logic [7:0] exp;} acrb_row_s;
  logic clk, rst_n, pdwn_pin, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, pat;
  logic lsb_first, power_down, standby, dcs_enable, pn_long_reset, pn_short_reset;
  logic self_test_control, bist_seq_reset, v;
  logic [2:0] test_pattern;
  int fail_count = 0;
  int cmp_count = 0;
  acrb_row_s rows [9] = '{'{8'h00, 8'h18}, '{8'h01, PART_CODE}, '{8'h02, {2'h0, GRADE, 4'h0}},
    '{8'h08, 8'h80}, '{8'h09, 8'h01}, '{8'h0D, 8'h00}, '{8'h0E, 8'h04}, '{8'hFF, 8'h00},
    '{8'h13, 8'h00}};
  acrb_bank #(.PART_ID(PART_CODE), .SPEED_GRADE(GRADE)) acrb_bank_i (.clk(clk),
    .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pdwn_pin(pdwn_pin), .lsb_first(lsb_first), .power_down(power_down),
    .standby(standby), .dcs_enable(dcs_enable), .test_pattern(test_pattern),
    .pn_long_reset(pn_long_reset), .pn_short_reset(pn_short_reset),
    .self_test_control(self_test_control), .bist_seq_reset(bist_seq_reset));
  acrb_host_model acrb_host_model_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));
  initial clk = 1'b0;
  always #2 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    acrb_host_model_i.rd(a, d, v);
    chk({7'h0, v}, 8'h01);
    chk(d, exp);
  endtask
  // commit, then let the working copy reach the output registers
  task automatic commit_wait();
    acrb_host_model_i.commit();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic check_rows();
    for (int i = 0; i < 9; i++) begin
      rd_chk(rows[i].addr, rows[i].exp);
    end
    chk({1'b0, lsb_first, power_down, standby, dcs_enable, test_pattern}, 8'h08);
    chk({4'h0, pn_long_reset, pn_short_reset, self_test_control, bist_seq_reset}, 8'h01);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    fail_count++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    pdwn_pin = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    check_rows();
    // held writes stay out of the converter until the commit lands on both at once
    acrb_host_model_i.wr(8'h0D, 8'h05);
    acrb_host_model_i.wr(8'h08, 8'h01);
    rd_chk(8'h0D, 8'h05);
    chk({power_down, 4'h0, test_pattern}, 8'h00);
    acrb_host_model_i.commit();
    @(posedge clk);
    #1;
    chk({power_down, 4'h0, test_pattern}, 8'h00);
    @(posedge clk);
    @(posedge clk);
    #1;
    chk({power_down, 4'h0, test_pattern}, 8'h85);
    rd_chk(8'hFF, 8'h00);
    for (int p = 0; p < 8; p++) begin
      pat = {2'h0, p[0], p[1], 1'b0, p[2:0]};
      acrb_host_model_i.wr(8'h0D, pat);
      commit_wait();
      chk({2'h0, pn_long_reset, pn_short_reset, 1'b0, test_pattern}, pat);
    end
    for (int m = 0; m < 4; m++) begin
      acrb_host_model_i.wr(8'h08, {6'h0, m[1:0]});
      commit_wait();
      chk({6'h0, power_down, standby}, {6'h0, m == 1, m == 2});
    end
    @(posedge clk);
    pdwn_pin <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({6'h0, power_down, standby}, 8'h02);
    acrb_host_model_i.wr(8'h08, 8'h20);
    commit_wait();
    chk({6'h0, power_down, standby}, 8'h01);
    @(posedge clk);
    pdwn_pin <= 1'b0;
    acrb_host_model_i.wr(8'h0E, 8'h01);
    acrb_host_model_i.wr(8'h09, 8'h00);
    commit_wait();
    chk({5'h0, self_test_control, bist_seq_reset, dcs_enable}, 8'h04);
    // read-only places must shrug off writes
    acrb_host_model_i.wr(8'h01, 8'hFF);
    acrb_host_model_i.wr(8'h02, 8'h30);
    rd_chk(8'h01, PART_CODE);
    rd_chk(8'h02, {2'h0, GRADE, 4'h0});
    // upper mirror copy alone sets the bit order
    acrb_host_model_i.wr(8'h00, 8'h40);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, lsb_first}, 8'h01);
    rd_chk(8'h00, 8'h5A);
    acrb_host_model_i.wr(8'h0D, 8'h03);
    // lower mirror copy alone triggers the soft reset
    acrb_host_model_i.wr(8'h00, 8'h04);
    repeat (3) @(posedge clk);
    check_rows();
    end_sim();
  end
endmodule // testbench
`default_nettype wire
